// File: testbench/dpc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_monitor (
	// clock and reset
	input	wire logic			ref_clk,
	input	wire logic			arst_n,
	// register bus
	input	wire logic [17:0]		avs_address,
	input	wire logic			avs_read,
	input	wire logic			avs_write,
	input	wire logic [31:0]		avs_readdata,
	input	wire logic			avs_waitrequest,
	// system and pins
	input	wire dpc_pkg::dpc_sys_t		sys,
	input	wire logic [7:0]		hi_data_out,
	input	wire logic [7:0]		hi_data_oe,
	input	wire logic [3:0]		upper_address_lines,
	input	wire dpc_pkg::dpc_pins4_t	p4_pins,
	input	wire dpc_pkg::dpc_pins5_t	p5_pins
);
	import dpc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic	run;
	logic	req;
	assign run = !sys.hw_standby && !sys.sw_standby;
	assign req = avs_read && avs_waitrequest;
	chk_ack_pulse: assert property (
		(avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	chk_dir_ones: assert property (
		req && (avs_address[17:2] == DPC_IDX_P4_DIR ||
		avs_address[17:2] == DPC_IDX_P5_DIR)
		|=> avs_readdata == 32'h0000_00FF)
		else $error("direction read not all ones");
	chk_p5_hi_ones: assert property (
		req && avs_address[17:2] == DPC_IDX_P5_LAT
		|=> avs_readdata[7:4] == 4'hF)
		else $error("port5 data upper bits not ones");
	chk_hw_off: assert property (
		sys.hw_standby |=> p4_pins.oe == 8'h00 &&
		p4_pins.pull == 8'h00 && p5_pins.oe == 4'h0 &&
		p5_pins.pull == 4'h0)
		else $error("pins active in hardware standby");
	chk_bus_wide: assert property (
		run && sys.mode != 3'h7 && !(&sys.bus_width_config)
		|=> p4_pins.out == $past(hi_data_out) &&
		p4_pins.oe == $past(hi_data_oe) && p4_pins.pull == 8'h00)
		else $error("port4 not on data bus");
	chk_addr_out: assert property (
		run && sys.mode <= DPC_MODE_ADDR_MAX |=> p5_pins.oe == 4'hF
		&& p5_pins.pull == 4'h0 &&
		p5_pins.out == $past(upper_address_lines))
		else $error("port5 not driving address");
	chk_pull_input: assert property (
		(p4_pins.pull & p4_pins.oe) == 8'h00 &&
		(p5_pins.pull & p5_pins.oe) == 4'h0)
		else $error("pull-up on a driven pin");
	chk_sw_hold: assert property (
		sys.sw_standby && !sys.hw_standby |=> $stable(p4_pins.out)
		&& $stable(p4_pins.oe) && $stable(p5_pins.out) &&
		$stable(p5_pins.oe))
		else $error("pins moved in software standby");
	cov_read: cover property (avs_read && !avs_waitrequest);
	cov_wide: cover property (run && !(&sys.bus_width_config));
	cov_sw: cover property (sys.sw_standby ##1 sys.sw_standby);
endmodule
bind dpc_top dpc_monitor mon_u (.ref_clk, .arst_n, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .sys,
	.hi_data_out, .hi_data_oe, .upper_address_lines, .p4_pins,
	.p5_pins);
`default_nettype wire

// File: testbench/dpc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_pin_model (
	// clock
	input	wire logic			ref_clk,
	// device side of the pins
	input	wire dpc_pkg::dpc_pins4_t	p4_pins,
	input	wire dpc_pkg::dpc_pins5_t	p5_pins,
	// far-side drivers
	input	wire logic [7:0]		ext4_en,
	input	wire logic [7:0]		ext4_val,
	input	wire logic [3:0]		ext5_en,
	input	wire logic [3:0]		ext5_val,
	// resolved wire levels
	output	logic [7:0]			p4_level,
	output	logic [3:0]			p5_level
);
	logic [11:0]	last_reg = 12'h000;
	logic [11:0]	lvl;
	logic [11:0]	oe;
	logic [11:0]	out;
	logic [11:0]	pull;
	logic [11:0]	en;
	logic [11:0]	val;
	assign oe = {p5_pins.oe, p4_pins.oe};
	assign out = {p5_pins.out, p4_pins.out};
	assign pull = {p5_pins.pull, p4_pins.pull};
	assign en = {ext5_en, ext4_en};
	assign val = {ext5_val, ext4_val};
	assign {p5_level, p4_level} = lvl;
	// undriven bits flip each cycle so a stale level never passes
	always_ff @(posedge ref_clk) begin
		last_reg <= lvl;
	end
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			lvl[i] = oe[i] ? out[i] : en[i] ? val[i] :
				pull[i] ? 1'b1 : ~last_reg[i];
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dpc_pkg::*;
	logic		ref_clk = 1'b0;
	logic		arst_n = 1'b0;
	logic [17:0]	avs_address = 18'h0_0000;
	logic		avs_read = 1'b0;
	logic		avs_write = 1'b0;
	logic [31:0]	avs_writedata = 32'h0000_0000;
	logic [3:0]	avs_byteenable = 4'h1;
	logic [31:0]	avs_readdata;
	logic		avs_waitrequest;
	dpc_sys_t	sys = '{3'h7, 8'hFF, 1'b0, 1'b0};
	logic [7:0]	hi_data_out = 8'hA5;
	logic [7:0]	hi_data_oe = 8'h3C;
	logic [3:0]	upper_address_lines = 4'hB;
	logic [7:0]	p4_lvl;
	logic [3:0]	p5_lvl;
	dpc_pins4_t	p4_pins;
	dpc_pins5_t	p5_pins;
	logic [31:0]	rd;
	int		err_total = 0;
	int		samples_checked = 0;
	dpc_top dut_u (.ref_clk, .arst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .sys, .hi_data_out, .hi_data_oe,
		.upper_address_lines, .p4_pin_in(p4_lvl), .p4_pins,
		.p5_pin_in(p5_lvl), .p5_pins);
	dpc_pin_model model_u (.ref_clk, .p4_pins, .p5_pins,
		.ext4_en(8'hFF), .ext4_val(8'h3C), .ext5_en(4'hF),
		.ext5_val(4'h9), .p4_level(p4_lvl), .p5_level(p5_lvl));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// holds the request until waitrequest is seen low
	task automatic acc(input logic w, input logic [15:0] i,
		input logic [7:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		// no local limit: only the watchdog ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		acc(1'b1, i, d, 4'h1);
	endtask
	task automatic rchk(input logic [15:0] i, input logic [7:0] e);
		acc(1'b0, i, 8'h00, 4'h1);
		chk(rd, {24'h00_0000, e});
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic s_reset();
		chk(32'(p4_pins), 32'h0000_0000);
		chk(32'(p5_pins), 32'h0000_0000);
		rchk(DPC_IDX_P4_DIR, 8'hFF);
		rchk(DPC_IDX_P5_DIR, 8'hFF);
		rchk(DPC_IDX_P4_LAT, 8'h3C);
		rchk(DPC_IDX_P4_PU, 8'h00);
		rchk(DPC_IDX_P5_LAT, 8'hF9);
		rchk(DPC_IDX_P5_PU, 8'hF0);
		rchk(16'h0000, 8'h00);
	endtask
	task automatic s_ports();
		wr(DPC_IDX_P4_LAT, 8'h5A);
		wr(DPC_IDX_P4_DIR, 8'hF0);
		wr(DPC_IDX_P4_PU, 8'hFF);
		wr(DPC_IDX_P5_LAT, 8'h06);
		wr(DPC_IDX_P5_DIR, 8'h03);
		wr(DPC_IDX_P5_PU, 8'h0F);
		acc(1'b1, DPC_IDX_P4_LAT, 8'h00, 4'h0);
		settle();
		chk(32'(p4_pins), 32'h005A_F00F);
		chk(32'(p5_pins), 32'h0000_063C);
		rchk(DPC_IDX_P4_LAT, 8'h5C);
		rchk(DPC_IDX_P5_LAT, 8'hFA);
		rchk(DPC_IDX_P5_PU, 8'h0F);
	endtask
	task automatic s_standby();
		@(posedge ref_clk);
		sys.sw_standby <= 1'b1;
		sys.mode <= 3'h5;
		settle();
		chk(32'(p5_pins), 32'h0000_063C);
		@(posedge ref_clk);
		sys.sw_standby <= 1'b0;
		settle();
		chk(32'(p5_pins), 32'h0000_0B3C);
		rchk(DPC_IDX_P4_PU, 8'hFF);
		@(posedge ref_clk);
		sys.bus_width_config <= 8'hFE;
		settle();
		chk(32'(p4_pins), 32'h00A5_3C00);
		@(posedge ref_clk);
		sys.bus_width_config <= 8'hFF;
		settle();
		chk(32'(p4_pins), 32'h005A_F00F);
		@(posedge ref_clk);
		sys.hw_standby <= 1'b1;
		settle();
		chk(32'(p4_pins) & 32'h0000_FFFF, 32'h0000_0000);
		chk(32'(p5_pins) & 32'h0000_00FF, 32'h0000_0000);
		@(posedge ref_clk);
		sys.hw_standby <= 1'b0;
		sys.mode <= 3'h7;
		settle();
		chk(32'(p4_pins), 32'h0000_0000);
		rchk(DPC_IDX_P4_PU, 8'h00);
		rchk(DPC_IDX_P5_PU, 8'hF0);
		rchk(DPC_IDX_P5_LAT, 8'hF9);
		// single-chip ignores the bus width: port4 stays generic
		@(posedge ref_clk);
		sys.bus_width_config <= 8'hFE;
		settle();
		chk(32'(p4_pins), 32'h0000_0000);
		@(posedge ref_clk);
		sys.bus_width_config <= 8'hFF;
		settle();
	endtask
	task automatic s_modes();
		wr(DPC_IDX_P5_DIR, 8'h05);
		for (int m = 1; m < 7; m++) begin
			@(posedge ref_clk);
			sys.mode <= 3'(m);
			if (m < 5) wr(DPC_IDX_P5_DIR, 8'h00);
			settle();
			chk(32'(p5_pins), m < 5 ? 32'h0BF0 : 32'h0B50);
			rchk(DPC_IDX_P5_DIR, 8'hFF);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		s_reset();
		s_ports();
		s_standby();
		s_modes();
		conclude();
	end
endmodule
`default_nettype wire

// File: verilog/dpc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// asynchronous pin levels in, filtered levels out
	input  wire logic [W-1:0] pin_async,
	output logic      [W-1:0] pin_sync
);
	import dpc_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} dpc_sync_state_t;

	dpc_sync_state_t r_reg;
	dpc_sync_state_t r_next;

	// ------------------------------------------------------------------
	// three stages, accept a bit once stages two and three agree
	// ------------------------------------------------------------------
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = pin_async;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// stage one feeds stage two only: metastability guard
		r_next.q  = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s3)
			| ((r_reg.s2 ^ r_reg.s3) & r_reg.q);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pin_sync = r_reg.q;

endmodule
`default_nettype wire

// File: verilog/dpc_pkg.sv
`default_nettype none
package dpc_pkg;

	// ------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam int             DPC_AW          = 18;
	localparam logic [15:0]    DPC_IDX_P4_DIR  = 16'hFFC5;
	localparam logic [15:0]    DPC_IDX_P4_LAT  = 16'hFFC7;
	localparam logic [15:0]    DPC_IDX_P4_PU   = 16'hFFDA;
	localparam logic [15:0]    DPC_IDX_P5_DIR  = 16'hFFC8;
	localparam logic [15:0]    DPC_IDX_P5_LAT  = 16'hFFCA;
	localparam logic [15:0]    DPC_IDX_P5_PU   = 16'hFFDB;

	// ------------------------------------------------------------------
	// reset values and fixed read patterns
	// ------------------------------------------------------------------
	localparam logic [7:0]     DPC_P4_DIR_RST  = 8'h00;
	localparam logic [7:0]     DPC_P4_LAT_RST  = 8'h00;
	localparam logic [7:0]     DPC_P4_PU_RST   = 8'h00;
	localparam logic [7:0]     DPC_P5_DIR_RST  = 8'hF0;
	localparam logic [7:0]     DPC_P5_LAT_RST  = 8'hF0;
	localparam logic [7:0]     DPC_P5_PU_RST   = 8'hF0;
	localparam logic [7:0]     DPC_DIR_READ    = 8'hFF;
	localparam logic [3:0]     DPC_P5_HI_ONES  = 4'hF;
	localparam logic [31:0]    DPC_RD_NONE     = 32'h0000_0000;
	localparam int             DPC_P5_LOW      = 0;
	localparam int             DPC_P5_HIGH     = 3;

	// ------------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------------
	localparam logic [2:0]     DPC_MODE_ADDR_MAX = 3'h4;
	localparam logic [2:0]     DPC_MODE_SINGLE   = 3'h7;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		DPC_SEL_NONE   = 3'h0,
		DPC_SEL_P4_DIR = 3'h1,
		DPC_SEL_P4_LAT = 3'h2,
		DPC_SEL_P4_PU  = 3'h3,
		DPC_SEL_P5_DIR = 3'h4,
		DPC_SEL_P5_LAT = 3'h5,
		DPC_SEL_P5_PU  = 3'h6
	} dpc_sel_t;

	typedef enum logic [1:0] {
		DPC_BUS_IDLE = 2'b00,
		DPC_BUS_ACK  = 2'b01
	} dpc_bus_st_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [7:0] bus_width_config;
		logic       hw_standby;
		logic       sw_standby;
	} dpc_sys_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
	} dpc_pins4_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] pull;
	} dpc_pins5_t;

endpackage
`default_nettype wire

// File: verilog/dpc_top.sv
// What this block does
// - single-chip: port4 pin drives latch when output
// - direction registers write-only, read all ones
// - port4 direction clears on reset, hardware standby
// - software standby keeps config, output pins hold
// - port4 data read: latch if output, else pin
// - port4 latch read/write, clears, kept in software standby
// - port4 pull-up on when input and enabled
// - port4 pull-ups off in reset, hardware standby, 16-bit
// - port4 pull-up enable clears, kept in software standby
// - modes 1-4: port5 address out, direction fixed
// - modes 5-6: port5 address out per direction bit
// - single-chip: port5 pin drives latch when output
// - port5 direction initialises F0, kept in software standby
// - port5 data read: latch if output, else pin
// - port5 data upper bits read one, ignore writes
// - port5 registers at FFC8, FFCA, FFDB
// - expanded 16-bit bus makes port4 data bus
// - modes 5-7: port5 pull-up when input, enabled
// - port5 pull-up enable initialises F0, kept in software standby
`timescale 1ns/100ps
`default_nettype none
module dpc_top (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        arst_n,
	// avalon-mm slave
	input  wire logic [dpc_pkg::DPC_AW-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// system configuration
	input  wire dpc_pkg::dpc_sys_t           sys,
	// upper data bus and address lines from the bus controller
	input  wire logic [7:0]                  hi_data_out,
	input  wire logic [7:0]                  hi_data_oe,
	input  wire logic [3:0]                  upper_address_lines,
	// port pins
	input  wire logic [7:0]                  p4_pin_in,
	output dpc_pkg::dpc_pins4_t              p4_pins,
	input  wire logic [3:0]                  p5_pin_in,
	output dpc_pkg::dpc_pins5_t              p5_pins
);
	import dpc_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		dpc_bus_st_t bus;
		logic        waitreq;
		logic [31:0] rdata;
		logic [7:0]  p4_dir;
		logic [7:0]  p4_lat;
		logic [7:0]  p4_pu;
		logic [7:0]  p5_dir;
		logic [7:0]  p5_lat;
		logic [7:0]  p5_pu;
		dpc_pins4_t  p4;
		dpc_pins5_t  p5;
	} dpc_state_t;

	localparam dpc_state_t DPC_STATE_RST = '{
		bus:     DPC_BUS_IDLE,
		waitreq: 1'b1,
		rdata:   DPC_RD_NONE,
		p4_dir:  DPC_P4_DIR_RST,
		p4_lat:  DPC_P4_LAT_RST,
		p4_pu:   DPC_P4_PU_RST,
		p5_dir:  DPC_P5_DIR_RST,
		p5_lat:  DPC_P5_LAT_RST,
		p5_pu:   DPC_P5_PU_RST,
		p4:      '0,
		p5:      '0
	};

	dpc_state_t  r_reg;
	dpc_state_t  r_next;

	logic [7:0]  p4_pin_s;
	logic [3:0]  p5_pin_s;
	dpc_sel_t    sel;
	logic        req;
	logic        single;
	logic        addr_fixed;
	logic        bus16;
	logic        wr_commit;
	logic [3:0]  p5_eff_dir;
	logic [31:0] rd;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// index decode
	function automatic dpc_sel_t decode(input logic [DPC_AW-1:0] a);
		logic [15:0] idx;
		idx = a[DPC_AW-1:2];
		if (idx == DPC_IDX_P4_DIR) begin
			decode = DPC_SEL_P4_DIR;
		end else if (idx == DPC_IDX_P4_LAT) begin
			decode = DPC_SEL_P4_LAT;
		end else if (idx == DPC_IDX_P4_PU) begin
			decode = DPC_SEL_P4_PU;
		end else if (idx == DPC_IDX_P5_DIR) begin
			decode = DPC_SEL_P5_DIR;
		end else if (idx == DPC_IDX_P5_LAT) begin
			decode = DPC_SEL_P5_LAT;
		end else if (idx == DPC_IDX_P5_PU) begin
			decode = DPC_SEL_P5_PU;
		end else begin
			decode = DPC_SEL_NONE;
		end
	endfunction

	// per bit: output pins read their latch, inputs read the pin
	function automatic logic [7:0] read_mux(
		input logic [7:0] dir,
		input logic [7:0] lat,
		input logic [7:0] pin
	);
		read_mux = (dir & lat) | (~dir & pin);
	endfunction

	function automatic logic [31:0] word(input logic [7:0] b);
		word = {24'h00_0000, b};
	endfunction

	// ------------------------------------------------------------------
	// pin input synchronisers
	// ------------------------------------------------------------------
	dpc_pin_sync #(
		.W(8)
	) u_sync4 (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.pin_async (p4_pin_in),
		.pin_sync  (p4_pin_s)
	);

	dpc_pin_sync #(
		.W(4)
	) u_sync5 (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.pin_async (p5_pin_in),
		.pin_sync  (p5_pin_s)
	);

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	always_comb begin
		single     = (sys.mode == DPC_MODE_SINGLE);
		// mode 0 is not a legal mode; treated like modes 1 to 4
		addr_fixed = (sys.mode <= DPC_MODE_ADDR_MAX);
		bus16      = !single && !(&sys.bus_width_config);
		p5_eff_dir = addr_fixed ? DPC_P5_HI_ONES
			: r_reg.p5_dir[DPC_P5_HIGH:DPC_P5_LOW];
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	always_comb begin
		sel = decode(avs_address);
		req = avs_read | avs_write;
		rd  = DPC_RD_NONE;
		case (sel)
			DPC_SEL_P4_DIR: begin
				rd = word(DPC_DIR_READ);
			end
			DPC_SEL_P4_LAT: begin
				rd = word(read_mux(r_reg.p4_dir, r_reg.p4_lat,
					p4_pin_s));
			end
			DPC_SEL_P4_PU: begin
				rd = word(r_reg.p4_pu);
			end
			DPC_SEL_P5_DIR: begin
				rd = word(DPC_DIR_READ);
			end
			DPC_SEL_P5_LAT: begin
				rd = word(read_mux({DPC_P5_HI_ONES, p5_eff_dir},
					r_reg.p5_lat, {DPC_P5_HI_ONES, p5_pin_s}));
			end
			DPC_SEL_P5_PU: begin
				rd = word(r_reg.p5_pu);
			end
			default: begin
				rd = DPC_RD_NONE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		r_next    = r_reg;
		wr_commit = 1'b0;

		// bus handshake: one wait cycle, then the commit edge
		case (r_reg.bus)
			DPC_BUS_IDLE: begin
				if (req) begin
					r_next.bus     = DPC_BUS_ACK;
					r_next.waitreq = 1'b0;
					r_next.rdata   = rd;
				end
			end
			DPC_BUS_ACK: begin
				r_next.bus     = DPC_BUS_IDLE;
				r_next.waitreq = 1'b1;
				wr_commit      = avs_write && avs_byteenable[0];
			end
			default: begin
				r_next.bus     = DPC_BUS_IDLE;
				r_next.waitreq = 1'b1;
			end
		endcase

		if (wr_commit) begin
			case (sel)
				DPC_SEL_P4_DIR: begin
					r_next.p4_dir = avs_writedata[7:0];
				end
				DPC_SEL_P4_LAT: begin
					r_next.p4_lat = avs_writedata[7:0];
				end
				DPC_SEL_P4_PU: begin
					r_next.p4_pu = avs_writedata[7:0];
				end
				DPC_SEL_P5_DIR: begin
					if (!addr_fixed) begin
						r_next.p5_dir[DPC_P5_HIGH:DPC_P5_LOW] =
							avs_writedata[DPC_P5_HIGH:DPC_P5_LOW];
					end
				end
				DPC_SEL_P5_LAT: begin
					r_next.p5_lat[DPC_P5_HIGH:DPC_P5_LOW] =
						avs_writedata[DPC_P5_HIGH:DPC_P5_LOW];
				end
				DPC_SEL_P5_PU: begin
					r_next.p5_pu = avs_writedata[7:0];
				end
				default: begin
					r_next.p5_pu = r_reg.p5_pu;
				end
			endcase
		end

		// port 4 pin function
		if (sys.hw_standby) begin
			r_next.p4 = '0;
		end else begin
			if (!sys.sw_standby) begin
				if (bus16) begin
					// pins belong to the data bus
					r_next.p4.out = hi_data_out;
					r_next.p4.oe  = hi_data_oe;
				end else begin
					r_next.p4.out = r_reg.p4_lat;
					r_next.p4.oe  = r_reg.p4_dir;
				end
			end
			r_next.p4.pull = bus16 ? 8'h00
				: (~r_reg.p4_dir & r_reg.p4_pu);
		end

		// port 5 pin function
		if (sys.hw_standby) begin
			r_next.p5 = '0;
		end else begin
			if (!sys.sw_standby) begin
				r_next.p5.out = single
					? r_reg.p5_lat[DPC_P5_HIGH:DPC_P5_LOW]
					: upper_address_lines;
				r_next.p5.oe  = p5_eff_dir;
			end
			// pull-up in modes 5 to 7
			r_next.p5.pull = addr_fixed ? 4'h0
				: (~p5_eff_dir & r_reg.p5_pu[DPC_P5_HIGH:DPC_P5_LOW]);
		end

		// hardware standby reinitialises, winning over any write
		if (sys.hw_standby) begin
			r_next.p4_dir = DPC_P4_DIR_RST;
			r_next.p4_lat = DPC_P4_LAT_RST;
			r_next.p4_pu  = DPC_P4_PU_RST;
			r_next.p5_dir = DPC_P5_DIR_RST;
			r_next.p5_lat = DPC_P5_LAT_RST;
			r_next.p5_pu  = DPC_P5_PU_RST;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	// reset loads the documented values
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= DPC_STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------------
	assign avs_readdata    = r_reg.rdata;
	assign avs_waitrequest = r_reg.waitreq;
	assign p4_pins         = r_reg.p4;
	assign p5_pins         = r_reg.p5;

endmodule
`default_nettype wire
